//--- core/mmu_bus_pkg.sv
// Purpose: Shared constants, types and helpers for the bus release and table walk block
// Assumes: APB register window, 32-bit data, one aligned word per register
// Notes:   Start-up overheads are counted in clock periods of ref_clk
package mmu_bus_pkg;
  // ==========================================================================
  // Register map
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_CMD    = 12'h008;
  localparam int CTRL_EARLY   = 0;
  localparam int CTRL_FCIDX   = 1;
  localparam int CTRL_DLY_LSB = 4;
  localparam int DLY_W        = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0013;
  localparam int CMD_PROBE    = 0;
  localparam int CMD_PRELOAD  = 1;
  localparam int ST_SRCH_LSB  = 0;
  localparam int ST_PHYS_LSB  = 4;
  localparam int ST_LEVEL_LSB = 8;
  localparam int ST_RMW       = 12;
  localparam int ST_INTV      = 13;
  localparam int ST_ORIG_LSB  = 16;
  // ==========================================================================
  // Timing counts, clock periods
  localparam int BASE_START_CYC  = 1;
  localparam int LIMIT_CHECK_CYC = 2;
  localparam int LATE_START_CYC  = 6;
  localparam int START_W         = 4;
  localparam int LEVEL_W         = 3;
  localparam logic [1:0] DSACK_32   = 2'h3;
  localparam logic [1:0] DSACK_NONE = 2'h0;
  // ==========================================================================
  // Types
  typedef enum logic [3:0] {S_IDLE, S_START, S_FETCH, S_UPD_RD, S_UPD_WR,
                            S_HANDOFF, S_AWAY, S_WAIT_RETRY} search_t;
  typedef enum logic [1:0] {P_OWN, P_GRANT, P_AWAY, P_RETURN} phys_t;
  typedef enum logic [1:0] {C_IDLE, C_ADDR, C_STROBE} cyc_t;
  typedef enum logic [1:0] {O_MISS, O_PROBE, O_PRELOAD} origin_t;
  typedef enum logic [1:0] {U_NONE, U_WRITE, U_RMW} upd_t;
  // ==========================================================================
  // Helpers
  function automatic upd_t status_update(input logic pageLevel, input logic needU, input logic needM);
    if (!needU && !needM) return U_NONE;
    if (pageLevel && needU && !needM) return U_RMW;
    return U_WRITE;
  endfunction : status_update

  function automatic logic [START_W-1:0] startup_cycles(input logic fcIdx, input logic early);
    int c;
    c = BASE_START_CYC + (fcIdx ? 0 : LIMIT_CHECK_CYC) + (early ? 0 : LATE_START_CYC);
    return START_W'(c);
  endfunction : startup_cycles
endpackage : mmu_bus_pkg

//--- core/mmu_bus_release.sv
// Purpose: Physical bus release, logical bus checking and table walk control
// Assumes: APB slave with zero wait states; descriptor contents come in on desc* inputs
// Notes:   Output enables are active low; the board resolves the shared wires
// Behaviour
// - Float physical address and strobe while the alternate master holds the bus.
// - Do not drive low address, size, code, strobe, lock, direction without ownership.
// - Keep physical grant low while any locked cycle is running.
// - A held-up logical cycle gets no strobe until the bus is owned again.
// - After acknowledge drops, drive address first, strobe after the decision delay.
// - Keep checking logical cycles and answering them regardless of acknowledge.
// - Still check rights, fault bad cycles, answer coprocessor, request retry on miss.
// - Add two cycles of limit check when the first level is not code-indexed.
// - Add six cycles before a search when early start is off.
// - Set used and modified together with one plain write.
// - Used-only update of a page descriptor uses a locked read-modify-write.
// - Used update above page level is always a plain write.
// - On logical grant in: finish cycle, then grant out and float together, then drop acknowledge.
// - Miss search waits for retry; resume if nothing intervened, else restart.
// - Probe or preload search resumes or restarts by itself.
// - Asynchronous inputs are synchronised within two clocks.
// - Arbitration outputs change on the edge after the synchronised input is valid.
`timescale 1ns/1ns
module mmu_bus_release
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  input  wire logic        physBusReq,
  input  wire logic        physGrantAck,
  output      logic        physBusGrant,
  output      logic [31:0] physAddr,
  output      logic        physAddrOe_n,
  output      logic        physAddrStrobe,
  output      logic        physAddrStrobeOe_n,
  input  wire logic        physCycleDone,
  output      logic        sharedCtrlOe_n,
  input  wire logic        lockedRmwIn,
  output      logic        lockedRmwOut,
  output      logic        lockedRmwOe_n,
  input  wire logic [31:0] logAddr,
  input  wire logic        logCycleValid,
  input  wire logic        logTargetLogical,
  input  wire logic        logCacheHit,
  input  wire logic        logAccessFault,
  input  wire logic        logCoprocCycle,
  input  wire logic        internalOpEvent,
  input  wire logic [31:0] descAddr,
  input  wire logic        descIsPage,
  input  wire logic        descNeedUsed,
  input  wire logic        descNeedModified,
  input  wire logic        logicalGrantIn,
  output      logic        logicalGrantOut,
  output      logic        logicalGrantAck,
  output      logic        logicalBusRequestOut,
  output      logic        logicalShareOe_n,
  output      logic        busFaultSignal,
  output      logic        haltSignal,
  output      logic        relinquishRetry,
  output      logic        cacheLoadInhibit,
  output      logic [1:0]  sizeAckStrobes
);
  import mmu_bus_pkg::*;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0073;

  // ==========================================================================
  // State
  typedef struct packed {
    search_t            srch;
    search_t            resume;
    phys_t              phys;
    cyc_t               cyc;
    origin_t            origin;
    logic [LEVEL_W-1:0] level;
    logic               rmw;
    logic               page;
    logic               intervened;
    logic               bySearch;
    logic [DLY_W-1:0]   dly;
    logic [31:0]        addr;
    logic               grant;
    logic               lgo;
    logic               ack;
    logic               fault;
    logic               relq;
    logic [1:0]         dsack;
    logic [31:0]        ctrl;
    logic [31:0]        rdata;
    logic               rerr;
    logic [START_W-1:0] sLen;
    logic [START_W-1:0] sExp;
  } mmu_st_t;
  mmu_st_t st_r, st_nxt;

  logic       reqS, ackS, lgiS;
  logic       tStart, tDone;
  logic       lockAny, transReq, missReq, cmdProbe, cmdPreload;
  logic       searchWants, cycStart, cycDone, searchDone, srchHolds;
  logic       apbWr;
  upd_t       upd;
  logic [31:0] statusWord;

  // ==========================================================================
  // Input synchronisation
  sync_two_stage #(.W(3)) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     ({physBusReq, physGrantAck, logicalGrantIn}),
    .dout    ({reqS, ackS, lgiS})
  );

  startup_timer u_timer (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .start      (tStart),
    .fcIndexed  (st_r.ctrl[CTRL_FCIDX]),
    .earlyStart (st_r.ctrl[CTRL_EARLY]),
    .done       (tDone)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    st_nxt      = st_r;
    tStart      = 1'b0;
    apbWr       = psel && penable && pwrite;
    cmdProbe    = apbWr && (paddr == REG_CMD) && pwdata[CMD_PROBE];
    cmdPreload  = apbWr && (paddr == REG_CMD) && pwdata[CMD_PRELOAD] && !pwdata[CMD_PROBE];
    lockAny     = lockedRmwIn || st_r.rmw;
    transReq    = logCycleValid && !logTargetLogical && logCacheHit && !logAccessFault && (st_r.srch == S_IDLE);
    missReq     = logCycleValid && !logCacheHit && !logAccessFault;
    searchWants = (st_r.srch inside {S_FETCH, S_UPD_RD, S_UPD_WR}) && (!lgiS || st_r.rmw);
    srchHolds   = st_r.srch inside {S_START, S_FETCH, S_UPD_RD, S_UPD_WR};
    cycStart    = (st_r.cyc == C_IDLE) && (st_r.phys == P_OWN) && (searchWants || transReq);
    cycDone     = (st_r.cyc == C_STROBE) && physCycleDone;
    searchDone  = cycDone && st_r.bySearch;
    upd         = status_update(descIsPage, descNeedUsed, descNeedModified);
    statusWord  = '0;
    statusWord[ST_SRCH_LSB +: 4]        = st_r.srch;
    statusWord[ST_PHYS_LSB +: 2]        = st_r.phys;
    statusWord[ST_LEVEL_LSB +: LEVEL_W] = st_r.level;
    statusWord[ST_RMW]                  = st_r.rmw;
    statusWord[ST_INTV]                 = st_r.intervened;
    statusWord[ST_ORIG_LSB +: 2]        = st_r.origin;

    // Logical-bus answers go on whoever owns the physical bus
    st_nxt.fault = logCycleValid && logAccessFault;
    st_nxt.dsack = (logCycleValid && logTargetLogical && logCoprocCycle && !logAccessFault)
                   ? DSACK_32 : DSACK_NONE;
    st_nxt.relq  = 1'b0;

    // ========================================================================
    // APB: read data captured in setup phase, so zero wait states
    if (psel && !penable) begin
      st_nxt.rerr = 1'b0;
      case (paddr)
        REG_CTRL:   st_nxt.rdata = st_r.ctrl;
        REG_STATUS: st_nxt.rdata = statusWord;
        REG_CMD:    st_nxt.rdata = '0;
        default: begin
          st_nxt.rdata = '0;
          st_nxt.rerr  = 1'b1;
        end
      endcase
    end
    if (apbWr && (paddr == REG_CTRL)) st_nxt.ctrl = pwdata & CTRL_MASK;

    // ========================================================================
    // Physical cycle engine
    case (st_r.cyc)
      C_IDLE: begin
        if (cycStart) begin
          st_nxt.cyc      = C_ADDR;
          st_nxt.bySearch = searchWants;
          st_nxt.addr     = searchWants ? descAddr : logAddr;
          st_nxt.dly      = st_r.ctrl[CTRL_DLY_LSB +: DLY_W];
        end
      end
      C_ADDR: begin
        if (st_r.dly <= DLY_W'(1)) st_nxt.cyc = C_STROBE;
        else st_nxt.dly = st_r.dly - DLY_W'(1);
      end
      C_STROBE: begin
        if (physCycleDone) st_nxt.cyc = C_IDLE;
      end
      default: st_nxt.cyc = C_IDLE;
    endcase

    // ========================================================================
    // Physical arbitration; a started cycle keeps the grant back until its strobe
    case (st_r.phys)
      P_OWN: begin
        if (reqS && !lockAny && (st_r.cyc != C_ADDR) && !cycStart) st_nxt.phys = P_GRANT;
      end
      P_GRANT: begin
        if (ackS) st_nxt.phys = P_AWAY;
        else if (!reqS) st_nxt.phys = P_OWN;
      end
      P_AWAY: begin
        if (!ackS) st_nxt.phys = P_RETURN;
      end
      P_RETURN: st_nxt.phys = P_OWN;
      default: st_nxt.phys = P_OWN;
    endcase
    st_nxt.grant = (st_nxt.phys == P_GRANT);

    // ========================================================================
    // Table search
    case (st_r.srch)
      S_IDLE: begin
        if (missReq || cmdProbe || cmdPreload) begin
          st_nxt.srch   = S_START;
          st_nxt.origin = missReq ? O_MISS : (cmdProbe ? O_PROBE : O_PRELOAD);
          st_nxt.relq   = missReq;
          tStart        = 1'b1;
        end
      end
      S_START: begin
        if (tDone) st_nxt.srch = S_FETCH;
      end
      S_FETCH: begin
        if (searchDone) begin
          st_nxt.page = descIsPage;
          case (upd)
            U_RMW: begin
              st_nxt.srch = S_UPD_RD;
              st_nxt.rmw  = 1'b1;
            end
            U_WRITE: st_nxt.srch = S_UPD_WR;
            default: begin
              if (descIsPage) st_nxt.srch = S_IDLE;
              else st_nxt.level = st_r.level + LEVEL_W'(1);
            end
          endcase
        end else if (lgiS && (st_r.cyc == C_IDLE)) begin
          st_nxt.srch   = S_HANDOFF;
          st_nxt.resume = S_FETCH;
        end
      end
      S_UPD_RD: begin
        if (searchDone) st_nxt.srch = S_UPD_WR;
      end
      S_UPD_WR: begin
        if (searchDone) begin
          st_nxt.rmw = 1'b0;
          if (st_r.page) st_nxt.srch = S_IDLE;
          else begin
            st_nxt.srch  = S_FETCH;
            st_nxt.level = st_r.level + LEVEL_W'(1);
          end
        end else if (lgiS && !st_r.rmw && (st_r.cyc == C_IDLE)) begin
          st_nxt.srch   = S_HANDOFF;
          st_nxt.resume = S_UPD_WR;
        end
      end
      S_HANDOFF: st_nxt.srch = S_AWAY;
      S_AWAY: begin
        if (!lgiS) begin
          if (st_r.origin == O_MISS) st_nxt.srch = S_WAIT_RETRY;
          else if (st_r.intervened) begin
            st_nxt.srch = S_START;
            tStart      = 1'b1;
          end else st_nxt.srch = st_r.resume;
        end
      end
      S_WAIT_RETRY: begin
        if (missReq) begin
          if (st_r.intervened) begin
            st_nxt.srch = S_START;
            tStart      = 1'b1;
          end else st_nxt.srch = st_r.resume;
        end else if (cmdProbe || cmdPreload) begin
          st_nxt.srch   = S_START;
          st_nxt.origin = cmdProbe ? O_PROBE : O_PRELOAD;
          tStart        = 1'b1;
        end
      end
      default: st_nxt.srch = S_IDLE;
    endcase
    if (tStart) begin
      st_nxt.level      = '0;
      st_nxt.intervened = 1'b0;
      st_nxt.sLen       = '0;
      st_nxt.sExp       = startup_cycles(st_r.ctrl[CTRL_FCIDX], st_r.ctrl[CTRL_EARLY]);
    end else if (st_r.srch == S_START) st_nxt.sLen = st_r.sLen + START_W'(1);
    // Anything the unit does while the bus is away spoils the saved position
    if ((st_r.srch inside {S_AWAY, S_WAIT_RETRY}) && (internalOpEvent || (logCycleValid && logCacheHit)))
      st_nxt.intervened = 1'b1;
    st_nxt.lgo = st_nxt.srch inside {S_HANDOFF, S_AWAY};
    st_nxt.ack = st_nxt.srch inside {S_START, S_FETCH, S_UPD_RD, S_UPD_WR, S_HANDOFF};
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r      <= '0;
      st_r.ctrl <= CTRL_RESET;
    end else st_r <= st_nxt;
  end

  // ==========================================================================
  // Outputs
  assign prdata               = st_r.rdata;
  assign pready               = 1'b1;
  assign pslverr              = st_r.rerr;
  assign physBusGrant         = st_r.grant && !lockedRmwIn && !st_r.rmw;
  assign physAddr             = st_r.addr;
  assign physAddrOe_n         = (st_r.phys == P_AWAY);
  assign physAddrStrobe       = (st_r.cyc == C_STROBE) && (st_r.phys != P_AWAY);
  assign physAddrStrobeOe_n   = (st_r.phys == P_AWAY);
  assign sharedCtrlOe_n       = !(srchHolds && (st_r.phys != P_AWAY));
  assign lockedRmwOut         = st_r.rmw;
  assign lockedRmwOe_n        = !(srchHolds && (st_r.phys != P_AWAY));
  assign logicalGrantOut      = st_r.lgo;
  assign logicalGrantAck      = st_r.ack;
  assign logicalBusRequestOut = (st_r.srch == S_AWAY) && (st_r.origin != O_MISS);
  assign logicalShareOe_n     = !srchHolds;
  assign busFaultSignal       = st_r.fault;
  // No halt source in this block; the pin is still owned here
  assign haltSignal           = 1'b0;
  assign relinquishRetry      = st_r.relq;
  // Retried data must not be cached
  assign cacheLoadInhibit     = st_r.relq;
  assign sizeAckStrobes       = st_r.dsack;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_float_away: assert property (st_r.phys == P_AWAY |-> physAddrOe_n && physAddrStrobeOe_n)
    else $error("physical address not floated while bus is away");
  chk_shared_release: assert property (st_r.phys == P_AWAY |-> sharedCtrlOe_n && lockedRmwOe_n)
    else $error("shared control driven without ownership");
  chk_grant_lock: assert property ((lockedRmwIn || lockedRmwOut) |-> !physBusGrant)
    else $error("grant during locked cycle");
  chk_strobe_held: assert property (st_r.phys inside {P_AWAY, P_RETURN} |-> !physAddrStrobe)
    else $error("strobe before bus regained");
  chk_addr_first: assert property ($rose(physAddrStrobe) |-> !physAddrOe_n && !$past(physAddrOe_n))
    else $error("strobe without address driven first");
  chk_sync_depth: assert property (physGrantAck [*2] |=> ackS)
    else $error("acknowledge not synchronised in two clocks");
  chk_arb_edge: assert property ($rose(ackS) && st_r.phys == P_GRANT |=> st_r.phys == P_AWAY)
    else $error("arbitration did not follow synchronised acknowledge");
  chk_fault_answer: assert property (logCycleValid && logAccessFault |=> busFaultSignal)
    else $error("faulting cycle not answered");
  chk_limit_check: assert property (st_r.srch == S_START && tDone && st_r.sExp == START_W'(3)
                                    |-> st_r.sLen == START_W'(2))
    else $error("limit check overhead wrong");
  chk_late_start: assert property (st_r.srch == S_START && tDone |-> st_r.sLen == st_r.sExp - START_W'(1))
    else $error("start-up overhead length wrong");
  chk_both_write: assert property (st_r.srch == S_FETCH && searchDone && descNeedUsed && descNeedModified
                                   |=> st_r.srch == S_UPD_WR && !lockedRmwOut)
    else $error("used and modified not one plain write");
  chk_rmw_page: assert property (st_r.srch == S_FETCH && searchDone && descIsPage && descNeedUsed
                                 && !descNeedModified |=> st_r.srch == S_UPD_RD && lockedRmwOut)
    else $error("page used update not locked");
  chk_upper_write: assert property (st_r.srch == S_FETCH && searchDone && !descIsPage && descNeedUsed
                                    |=> !lockedRmwOut)
    else $error("upper level used update locked");
  chk_handoff_order: assert property ($rose(logicalGrantOut)
                                     |-> logicalShareOe_n && logicalGrantAck ##1 !logicalGrantAck)
    else $error("acknowledge dropped before float");
  chk_miss_waits: assert property (st_r.srch == S_AWAY && st_r.origin == O_MISS && !lgiS
                                   |=> st_r.srch == S_WAIT_RETRY)
    else $error("miss search did not wait for retry");
  chk_auto_resume: assert property (st_r.srch == S_AWAY && st_r.origin != O_MISS && !lgiS
                                    |=> st_r.srch inside {S_START, S_FETCH, S_UPD_WR})
    else $error("probe search did not resume");

  cov_handoff: cover property (st_r.srch == S_HANDOFF ##1 st_r.srch == S_AWAY);
  cov_rmw: cover property (st_r.srch == S_UPD_RD ##[1:20] st_r.srch == S_UPD_WR);
  cov_regain: cover property (st_r.phys == P_RETURN ##[1:20] $rose(physAddrStrobe));
endmodule : mmu_bus_release

//--- core/startup_timer.sv
// Purpose: Counts the start-up overhead before a table search
// Assumes: start is a one-cycle pulse
// Notes:   done is high in the last overhead cycle
`timescale 1ns/1ns
module startup_timer
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic fcIndexed,
  input  wire logic earlyStart,
  output      logic done
);
  import mmu_bus_pkg::*;
  typedef struct packed {
    logic [START_W-1:0] cnt;
  } tmr_st_t;
  tmr_st_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (start) st_nxt.cnt = startup_cycles(fcIndexed, earlyStart);
    else if (st_r.cnt != '0) st_nxt.cnt = st_r.cnt - START_W'(1);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) st_r <= '0;
    else st_r <= st_nxt;
  end

  assign done = (st_r.cnt == START_W'(1));
endmodule : startup_timer

//--- core/sync_two_stage.sv
// Purpose: Two flip-flop synchroniser for asynchronous inputs
// Assumes: Single clock ref_clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ns
module sync_two_stage #(
  parameter int W = 3
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output      logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_st_t;
  sync_st_t st_r, st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) st_r <= '0;
    else st_r <= st_nxt;
  end

  assign dout = st_r.s2;
endmodule : sync_two_stage

//--- dv/far_side_model.sv
// Purpose: Alternate physical master and descriptor memory
// Assumes: Signals change just after ref_clk edges
// Notes:   Memory answers fast and slow in turn
`timescale 1ns/1ns
module far_side_model (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic wantBus,
  input  wire logic physBusGrant,
  input  wire logic physAddrStrobe,
  output      logic physBusReq,
  output      logic physGrantAck,
  output      logic physCycleDone
);
  logic [1:0] cnt_r;
  logic       slow_r;
  // ==========================================================================
  // Arbitration and memory answers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {physBusReq, physGrantAck, physCycleDone, cnt_r, slow_r} <= '0;
    end else begin
      physBusReq <= wantBus & !physGrantAck;
      // Take over only once the strobe is idle
      physGrantAck <= wantBus & (physGrantAck | (physBusGrant & !physAddrStrobe));
      physCycleDone <= physAddrStrobe & !physCycleDone & (cnt_r >= {slow_r, 1'b0});
      cnt_r <= (physAddrStrobe & !physCycleDone) ? cnt_r + 2'h1 : 2'h0;
      if (physCycleDone) slow_r <= !slow_r;
    end
  end
endmodule : far_side_model

//--- dv/mmu_bus_release_and_table_walk_tb.sv
// Purpose: Self-checking bench for bus release and table walk
// Assumes: far_side_model answers physical cycles
// Notes:   Start-up overhead checked as differences
`timescale 1ns/1ns
`define CHK(n, e, s) begin cmpCount++; if ((e) !== (s)) begin fails++; $display("unexpected %s %h %h", n, e, s); end end
module mmu_bus_release_and_table_walk_tb;
  import mmu_bus_pkg::*;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, physBusReq, physGrantAck, physBusGrant, physAddrOe_n;
  logic physAddrStrobe, physAddrStrobeOe_n, physCycleDone, sharedCtrlOe_n, lockedRmwIn, lockedRmwOut, lockedRmwOe_n;
  logic logCycleValid, logTargetLogical, logCacheHit, logAccessFault, logCoprocCycle, internalOpEvent, descIsPage;
  logic descNeedUsed, descNeedModified, logicalGrantIn, logicalGrantOut, logicalGrantAck, logicalBusRequestOut;
  logic logicalShareOe_n, busFaultSignal, haltSignal, relinquishRetry, cacheLoadInhibit, wantBus, sawLock, sawRetry;
  logic [1:0]  sizeAckStrobes;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, physAddr, logAddr, descAddr, r;
  logic [32:0] e, expQ[$];
  int          fails, cmpCount, t, t0;
  mmu_bus_release i_dut (.*);
  far_side_model  i_far (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) expQ.push_back(x);
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (!pready);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  // ==========================================================================
  // Clock, monitor, watchdog
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (lockedRmwOut) sawLock = 1'b1;
    if (relinquishRetry && cacheLoadInhibit) sawRetry = 1'b1;
    if (psel && penable && pready && !pwrite) begin
      e = expQ.pop_front();
      `CHK("apb", e, {pslverr, prdata})
    end
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    summarize();
  end
  // ==========================================================================
  // Scenarios
  initial begin
    {psel, penable, pwrite, paddr, pwdata, lockedRmwIn, logAddr, logCycleValid, logTargetLogical} = '0;
    {logCacheHit, logAccessFault, logCoprocCycle, internalOpEvent, descAddr, descNeedModified} = '0;
    {logicalGrantIn, wantBus, sawLock, sawRetry, descIsPage, descNeedUsed} = 6'h3;
    r = 32'h0001_6491;
    rst = 1'b1;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    apb(1'b0, REG_CTRL, '0, {1'b0, CTRL_RESET});
    apb(1'b0, 12'h00c, '0, 33'h1_0000_0000);
    repeat (2) begin
      r = lfsr(r);
      apb(1'b1, REG_CTRL, r, '0);
      apb(1'b0, REG_CTRL, '0, {1'b0, r & 32'h0000_0073});
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, REG_CTRL, {30'h0000_0004, ~i[1:0]}, '0);
      descAddr <= lfsr(r);
      descNeedModified <= i[0];
      sawLock = 1'b0;
      apb(1'b1, REG_CMD, {30'h0, i[0], ~i[0]}, '0);
      for (t = 0; !physAddrStrobe; t++) @(posedge ref_clk);
      if (i == 0) t0 = t;
      `CHK("startup", t - t0, (i[0] ? 6 : 0) + (i[1] ? 2 : 0))
      `CHK("desc", physAddr, lfsr(r))
      while (logicalGrantAck) @(posedge ref_clk);
      `CHK("rmw", sawLock, !i[0])
    end
    logAddr <= r;
    logCycleValid <= 1'b1;
    repeat (4) @(posedge ref_clk);
    `CHK("retry", sawRetry, 1'b1)
    logCycleValid <= 1'b0;
    while (logicalGrantAck) @(posedge ref_clk);
    lockedRmwIn <= 1'b1;
    wantBus <= 1'b1;
    t = 0;
    repeat (8) @(posedge ref_clk) t |= physBusGrant;
    `CHK("lock", t, 0)
    lockedRmwIn <= 1'b0;
    while (!physGrantAck) @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
    `CHK("float", {physAddrOe_n, physAddrStrobeOe_n, sharedCtrlOe_n, lockedRmwOe_n}, 4'hf)
    for (int f = 0; f < 2; f++) begin
      {logTargetLogical, logCacheHit, logCoprocCycle, logAccessFault} <= {3'h7, f[0]};
      logCycleValid <= 1'b1;
      t = 0;
      repeat (6) @(posedge ref_clk) t |= {sizeAckStrobes == DSACK_32, busFaultSignal};
      `CHK("logical", t, f ? 1 : 2)
      `CHK("halt", haltSignal, 1'b0)
      logCycleValid <= 1'b0;
      @(posedge ref_clk);
    end
    {logTargetLogical, logCoprocCycle, logAccessFault, logCycleValid} <= 4'h1;
    t = 0;
    repeat (6) @(posedge ref_clk) t |= physAddrStrobe;
    `CHK("held", t, 0)
    wantBus <= 1'b0;
    while (!physAddrStrobe) @(posedge ref_clk);
    `CHK("addr", physAddrOe_n, 1'b0)
    `CHK("paddr", physAddr, r)
    while (!physCycleDone) @(posedge ref_clk);
    logCycleValid <= 1'b0;
    repeat (4) @(posedge ref_clk);
    // Logical bus taken away mid-search: probe resumes, miss waits and restarts
    for (int m = 0; m < 2; m++) begin
      descIsPage <= 1'b0;
      sawLock = 1'b0;
      if (m == 0) apb(1'b1, REG_CMD, 32'h0000_0001, '0);
      else begin
        logCacheHit <= 1'b0;
        logCycleValid <= 1'b1;
        @(posedge ref_clk);
        logCycleValid <= 1'b0;
      end
      while (!physAddrStrobe) @(posedge ref_clk);
      logicalGrantIn <= 1'b1;
      while (!logicalGrantOut) @(posedge ref_clk);
      `CHK("handoff", {logicalShareOe_n, logicalGrantAck}, 2'h3)
      @(posedge ref_clk);
      `CHK("away", {logicalGrantAck, logicalBusRequestOut}, {1'b0, m == 0})
      logicalGrantIn <= 1'b0;
      descIsPage <= 1'b1;
      internalOpEvent <= m[0];
      @(posedge ref_clk);
      internalOpEvent <= 1'b0;
      if (m == 1) begin
        repeat (8) @(posedge ref_clk);
        `CHK("wait", logicalGrantAck, 1'b0)
        logCycleValid <= 1'b1;
        t = 0;
        repeat (5) @(posedge ref_clk) t |= physAddrStrobe;
        `CHK("restart", t, 0)
        logCycleValid <= 1'b0;
      end
      while (logicalGrantOut || logicalGrantAck) @(posedge ref_clk);
      `CHK("walk", sawLock, 1'b0)
    end
    summarize();
  end
endmodule : mmu_bus_release_and_table_walk_tb
